/* File: common/adcrc_pkg.sv */
package adcrc_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [2:0] OFF_CTRL_ONE = 3'h0;
  localparam logic [2:0] OFF_CTRL_TWO = 3'h1;
  localparam logic [2:0] OFF_RES_UP   = 3'h2;
  localparam logic [2:0] OFF_RES_LO   = 3'h3;
  localparam logic [2:0] OFF_CMP_UP   = 3'h4;
  localparam logic [2:0] OFF_CMP_LO   = 3'h5;
  localparam logic [2:0] OFF_CONFIG   = 3'h6;

  // control_status_one fields
  localparam int unsigned CS1_DONE_BIT = 7;
  localparam int unsigned CS1_CHAN_LSB = 0;
  localparam int unsigned CHAN_W       = 5;

  // control_status_two fields
  localparam int unsigned CS2_ACTIVE_BIT = 7;
  localparam int unsigned CS2_TRIG_BIT   = 6;
  localparam int unsigned CS2_CMPEN_BIT  = 5;
  localparam int unsigned CS2_GTE_BIT    = 4;

  // converter_config fields
  localparam int unsigned CFG_MODE_LSB = 2;
  localparam int unsigned MODE_W       = 2;

  // Channel select codes
  localparam logic [4:0] CHAN_LAST_INPUT = 5'h1b;
  localparam logic [4:0] CHAN_RESERVED   = 5'h1c;
  localparam logic [4:0] CHAN_HIGH_REF   = 5'h1d;
  localparam logic [4:0] CHAN_LOW_REF    = 5'h1e;
  localparam logic [4:0] CHAN_DISABLED   = 5'h1f;

  // Conversion mode codes
  localparam logic [1:0] MODE_8BIT  = 2'h0;
  localparam logic [1:0] MODE_10BIT = 2'h2;

  // Result geometry
  localparam int unsigned RES_W = 10;

  // Reset values
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_BYTE   = 8'h00;

  typedef enum logic [1:0] {
    ADCRC_IDLE = 2'b00,
    ADCRC_CONV = 2'b01
  } adcrc_state_e_t;

endpackage

/* File: src/adcrc_trig_sync.sv */
`timescale 1ns/1ps
module adcrc_trig_sync (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // Trigger
  input  wire logic trig_i,
  output logic      pulse_o
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic pulse;
  } adcrc_sync_t;

  adcrc_sync_t s_q;
  adcrc_sync_t s_d;

  // Only the second stage and its delayed copy feed the edge detector; the first may be metastable
  always_comb begin
    s_d       = s_q;
    s_d.meta  = trig_i;
    s_d.sync  = s_q.meta;
    s_d.prev  = s_q.sync;
    s_d.pulse = s_q.sync && !s_q.prev;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pulse_o = s_q.pulse;

  a_trig_one_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    pulse_o |=> !pulse_o)
    else $error("trigger pulse longer than one cycle");

endmodule

/* File: src/adcrc_top.sv */
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module adcrc_top
  import adcrc_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                rst_n_i,
  // Register port
  input  wire logic [ADDR_W-1:0]   addr_i,
  input  wire logic [DATA_W-1:0]   wr_data_i,
  input  wire logic                wr_en_i,
  input  wire logic                rd_en_i,
  output logic      [DATA_W-1:0]   rd_data_o,
  // Hardware trigger
  input  wire logic                hardware_trigger_in_i,
  // Analog core
  input  wire logic                core_done_i,
  input  wire logic [RES_W-1:0]    core_result_i,
  output logic                     core_start_o,
  output logic                     core_abort_o,
  output logic      [CHAN_W-1:0]   core_channel_o,
  output logic      [MODE_W-1:0]   core_mode_o,
  output logic                     conversion_active_o
);

  typedef struct packed {
    adcrc_state_e_t  st;
    logic [4:0]      channel_select;
    logic            conversion_done_flag;
    logic            trigger_select;
    logic            compare_enable;
    logic            compare_gte;
    logic [1:0]      result_upper;
    logic [7:0]      result_lower;
    logic [1:0]      compare_bits_upper;
    logic [7:0]      compare_bits_lower;
    logic [7:0]      converter_config;
    logic            lock;
    logic [7:0]      rdata;
    logic            start;
    logic            abort;
  } adcrc_state_t;

  adcrc_state_t s_q;
  adcrc_state_t s_d;

  logic             trig_pulse;
  logic             wr_cs1;
  logic             rd_upper;
  logic             rd_lower;
  logic             mode10;
  logic             done_ok;
  logic [RES_W-1:0] res_cmp;
  logic [RES_W-1:0] cv_cmp;
  logic             cond;
  logic             store_ok;
  logic [4:0]       chan_next;
  logic             sw_start;
  logic             hw_start;

  adcrc_trig_sync u_trig_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .trig_i    (hardware_trigger_in_i),
    .pulse_o   (trig_pulse)
  );

  always_comb begin
    wr_cs1    = wr_en_i && (addr_i == OFF_CTRL_ONE);
    rd_upper  = rd_en_i && (addr_i == OFF_RES_UP);
    rd_lower  = rd_en_i && (addr_i == OFF_RES_LO);
    mode10    = s_q.converter_config[CFG_MODE_LSB +: MODE_W] == MODE_10BIT;
    // Stray done strobes outside a conversion are ignored
    done_ok   = core_done_i && (s_q.st == ADCRC_CONV);
    // 8-bit mode drops the upper compare bits from both sides
    res_cmp   = mode10 ? core_result_i : {2'b00, core_result_i[7:0]};
    cv_cmp    = mode10 ? {s_q.compare_bits_upper, s_q.compare_bits_lower}
                       : {2'b00, s_q.compare_bits_lower};
    cond      = s_q.compare_gte ? (res_cmp >= cv_cmp) : (res_cmp < cv_cmp);
    store_ok  = done_ok && (!s_q.compare_enable || cond);
    chan_next = wr_cs1 ? wr_data_i[CS1_CHAN_LSB +: CHAN_W] : s_q.channel_select;
    // Any code but the disable code runs the core, reserved ones included
    sw_start  = wr_cs1 && !s_q.trigger_select && (chan_next != CHAN_DISABLED);
    hw_start  = trig_pulse && s_q.trigger_select && (chan_next != CHAN_DISABLED)
                && ((s_q.st == ADCRC_IDLE) || done_ok || wr_cs1);
  end

  always_comb begin
    s_d       = s_q;
    s_d.start = 1'b0;
    s_d.abort = 1'b0;
    s_d.rdata = RST_BYTE;

    // Completion and result transfer
    if (done_ok) begin
      s_d.st = ADCRC_IDLE;
    end
    if (store_ok) begin
      s_d.conversion_done_flag = 1'b1;
      // A result finished while locked is dropped, not queued
      if (!s_q.lock) begin
        s_d.result_upper = mode10 ? core_result_i[9:8] : 2'b00;
        s_d.result_lower = core_result_i[7:0];
      end
    end

    // Clears lose to a set in the same cycle
    if ((wr_cs1 || rd_lower) && !store_ok) begin
      s_d.conversion_done_flag = 1'b0;
    end

    // Interlock exists only in 10-bit mode
    if (rd_upper && mode10) begin
      s_d.lock = 1'b1;
    end
    if (rd_lower) begin
      s_d.lock = 1'b0;
    end

    // Register writes
    if (wr_en_i) begin
      unique case (addr_i)
        OFF_CTRL_ONE: s_d.channel_select = wr_data_i[CS1_CHAN_LSB +: CHAN_W];
        OFF_CTRL_TWO: begin
          s_d.trigger_select = wr_data_i[CS2_TRIG_BIT];
          s_d.compare_enable = wr_data_i[CS2_CMPEN_BIT];
          s_d.compare_gte    = wr_data_i[CS2_GTE_BIT];
        end
        OFF_CMP_UP:   s_d.compare_bits_upper = wr_data_i[1:0];
        OFF_CMP_LO:   s_d.compare_bits_lower = wr_data_i;
        OFF_CONFIG: begin
          s_d.converter_config = wr_data_i;
          // Old results are stale; drop a pending lock so new ones can land
          if (wr_data_i[CFG_MODE_LSB +: MODE_W] != s_q.converter_config[CFG_MODE_LSB +: MODE_W]) begin
            s_d.lock = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Abort on any control one write while a conversion runs, unless it completes in the same cycle
    if (wr_cs1 && (s_q.st == ADCRC_CONV) && !done_ok) begin
      s_d.abort = 1'b1;
      s_d.st    = ADCRC_IDLE;
    end
    if (sw_start || hw_start) begin
      s_d.start = 1'b1;
      s_d.st    = ADCRC_CONV;
    end

    // Read data, valid in the cycle after the strobe
    if (rd_en_i) begin
      unique case (addr_i)
        OFF_CTRL_ONE: s_d.rdata = {s_q.conversion_done_flag, 2'b00, s_q.channel_select};
        OFF_CTRL_TWO: s_d.rdata = {s_q.st == ADCRC_CONV, s_q.trigger_select,
                                   s_q.compare_enable, s_q.compare_gte, 4'h0};
        OFF_RES_UP:   s_d.rdata = {6'h00, mode10 ? s_q.result_upper : 2'b00};
        OFF_RES_LO:   s_d.rdata = s_q.result_lower;
        OFF_CMP_UP:   s_d.rdata = {6'h00, s_q.compare_bits_upper};
        OFF_CMP_LO:   s_d.rdata = s_q.compare_bits_lower;
        OFF_CONFIG:   s_d.rdata = s_q.converter_config;
        default:      s_d.rdata = RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q                    <= '0;
      s_q.st                 <= ADCRC_IDLE;
      s_q.channel_select     <= CHAN_DISABLED;
      s_q.conversion_done_flag <= 1'b0;
      s_q.converter_config   <= RST_CONFIG;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data_o           = s_q.rdata;
  assign core_start_o        = s_q.start;
  assign core_abort_o        = s_q.abort;
  assign core_channel_o      = s_q.channel_select;
  assign core_mode_o         = s_q.converter_config[CFG_MODE_LSB +: MODE_W];
  assign conversion_active_o = s_q.st == ADCRC_CONV;

  a_abort_on_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_cs1 && conversion_active_o && !core_done_i) |=> core_abort_o)
    else $error("control write did not abort conversion");

  a_sw_start_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_cs1 && !s_q.trigger_select && wr_data_i[4:0] != CHAN_DISABLED)
      |=> (core_start_o && conversion_active_o))
    else $error("software write did not start conversion");

  a_no_start_disabled: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    core_start_o |-> (core_channel_o != CHAN_DISABLED))
    else $error("conversion started on disabled channel");

  a_done_no_compare: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (core_done_i && conversion_active_o && !s_q.compare_enable)
      |=> s_q.conversion_done_flag)
    else $error("done flag not set after conversion");

  a_done_cmp_false: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (core_done_i && conversion_active_o && s_q.compare_enable && !cond
      && !s_q.conversion_done_flag)
      |=> !s_q.conversion_done_flag)
    else $error("done flag set with compare false");

  a_done_clear_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (rd_lower && !store_ok) |=> !s_q.conversion_done_flag)
    else $error("done flag not cleared by lower read");

  a_active_ends: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (core_done_i && conversion_active_o && !sw_start && !hw_start)
      |=> !conversion_active_o)
    else $error("active bit stayed high after completion");

  a_result_cmp_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (core_done_i && conversion_active_o && s_q.compare_enable && !cond)
      |=> ($stable(s_q.result_lower) && $stable(s_q.result_upper)))
    else $error("result updated with compare false");

  a_lock_holds: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_q.lock |=> $stable(s_q.result_lower))
    else $error("result changed while locked");

  a_upper_zero_8bit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (rd_upper && !mode10) |=> (rd_data_o == 8'h00))
    else $error("upper result not zero in 8-bit mode");

endmodule

/* File: testbench/adcrc_top_tb.sv */
`timescale 1ns/1ps
module adcrc_top_tb;
  import adcrc_pkg::*;
  // Design ports
  logic              ref_clk_i;
  logic              rst_n_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wr_data_i;
  logic              wr_en_i;
  logic              rd_en_i;
  logic [DATA_W-1:0] rd_data_o;
  logic              hardware_trigger_in_i;
  logic              core_done_i;
  logic [RES_W-1:0]  core_result_i;
  logic              core_start_o;
  logic              core_abort_o;
  logic [CHAN_W-1:0] core_channel_o;
  logic [MODE_W-1:0] core_mode_o;
  logic              conversion_active_o;
  // Reference model and bookkeeping
  int                err_count;
  int                samples_checked;
  int                seed;
  int                m_done, m_act, m_chan, m_trig, m_cmp, m_gte;
  int                m_cvh, m_cvl, m_cfg, m_res, m_lock;
  int                chs[5] = '{0, 27, 28, 29, 30};
  int                modes[3] = '{8, 0, 12};
  int                n;
  logic [9:0]        r;

  adcrc_top u_adcrc_top (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .hardware_trigger_in_i(hardware_trigger_in_i), .core_done_i(core_done_i),
    .core_result_i(core_result_i), .core_start_o(core_start_o), .core_abort_o(core_abort_o),
    .core_channel_o(core_channel_o), .core_mode_o(core_mode_o),
    .conversion_active_o(conversion_active_o));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic bit m10();
    return m_cfg[3:2] == MODE_10BIT;
  endfunction

  function automatic int mcv();
    return m10() ? (m_cvh & 3) * 256 + (m_cvl & 255) : (m_cvl & 255);
  endfunction

  function automatic logic [7:0] mrd(input logic [2:0] a);
    case (a)
      OFF_CTRL_ONE: return {m_done[0], 2'b00, m_chan[4:0]};
      OFF_CTRL_TWO: return {m_act[0], m_trig[0], m_cmp[0], m_gte[0], 4'h0};
      OFF_RES_UP:   return m10() ? {6'h00, m_res[9:8]} : 8'h00;
      OFF_RES_LO:   return m_res[7:0];
      OFF_CMP_UP:   return {6'h00, m_cvh[1:0]};
      OFF_CMP_LO:   return m_cvl[7:0];
      OFF_CONFIG:   return m_cfg[7:0];
      default:      return 8'h00;
    endcase
  endfunction

  task automatic rd(input logic [2:0] a);
    logic [7:0] d;
    @(posedge ref_clk_i);
    addr_i  <= a;
    rd_en_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_en_i <= 1'b0;
    #1 d = rd_data_o;
    chk(d, mrd(a));
    if (a == OFF_RES_LO) begin
      m_done = 0;
      m_lock = 0;
    end
    if (a == OFF_RES_UP && m10()) m_lock = 1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    int was;
    was = m_act;
    @(posedge ref_clk_i);
    addr_i    <= a;
    wr_data_i <= v;
    wr_en_i   <= 1'b1;
    @(posedge ref_clk_i);
    wr_en_i <= 1'b0;
    case (a)
      OFF_CTRL_ONE: begin
        m_chan = v[4:0];
        m_done = 0;
        m_act  = (v[4:0] != CHAN_DISABLED) && (m_trig == 0);
      end
      OFF_CTRL_TWO: begin
        m_trig = v[6];
        m_cmp  = v[5];
        m_gte  = v[4];
      end
      OFF_CMP_UP: m_cvh = v;
      OFF_CMP_LO: m_cvl = v;
      OFF_CONFIG: begin
        if (v[3:2] != m_cfg[3:2]) m_lock = 0;
        m_cfg = v;
      end
      default: ;
    endcase
    #1;
    if (a == OFF_CTRL_ONE) begin
      chk(core_start_o, m_act[0]);
      chk(core_channel_o, m_chan[4:0]);
      if (was != 0) chk(core_abort_o, 1'b1);
    end
    chk(conversion_active_o, m_act[0]);
    chk(core_mode_o, m_cfg[3:2]);
  endtask

  task automatic conv(input logic [9:0] rr);
    int v, c;
    v = m10() ? rr : rr[7:0];
    c = m_cmp ? (m_gte ? v >= mcv() : v < mcv()) : 1;
    @(posedge ref_clk_i);
    core_done_i   <= 1'b1;
    core_result_i <= rr;
    @(posedge ref_clk_i);
    core_done_i <= 1'b0;
    if (m_act != 0 && c != 0) begin
      m_done = 1;
      if (m_lock == 0) m_res = v;
    end
    m_act = 0;
    #1 chk(conversion_active_o, 1'b0);
  endtask

  initial begin
    #(40 * 20000);
    err_count++;
    results();
  end

  initial begin
    seed = 32'h2a3e_ca2c;
    {addr_i, wr_data_i, wr_en_i, rd_en_i, hardware_trigger_in_i} = '0;
    {core_done_i, core_result_i} = '0;
    {m_done, m_act, m_trig, m_cmp, m_gte, m_cvh, m_cvl, m_res, m_lock} = '0;
    m_chan = CHAN_DISABLED;
    m_cfg  = RST_CONFIG;
    rst_n_i = 1'b0;
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    chk(core_channel_o, CHAN_DISABLED);
    for (int a = 0; a < 8; a++) rd(a);
    wr(7, 8'hff);
    rd(7);
    $display("reset and map test done");
    // Channel codes, software trigger, done flag and clearing, 10-bit results
    wr(OFF_CONFIG, 8'h08);
    for (int i = 0; i < 12; i++) begin
      hardware_trigger_in_i <= $random(seed);
      wr(OFF_CTRL_ONE, i < 5 ? chs[i] : {$random(seed)} % 28);
      r = $random(seed);
      conv(r);
      for (int a = 0; a < 4; a++) rd(a);
      rd(OFF_CTRL_ONE);
    end
    hardware_trigger_in_i <= 1'b0;
    wr(OFF_CTRL_ONE, 8'h9f);
    conv(10'h155);
    rd(OFF_CTRL_ONE);
    wr(OFF_CTRL_ONE, 8'h03);
    wr(OFF_CTRL_ONE, 8'h05);
    conv(10'h2aa);
    rd(OFF_RES_LO);
    $display("software conversion test done");
    // Compare sense and value in both modes
    for (int md = 0; md < 2; md++) begin
      wr(OFF_CONFIG, md ? 8'h08 : 8'h00);
      for (int g = 0; g < 2; g++) begin
        for (int k = 0; k < 4; k++) begin
          wr(OFF_CTRL_TWO, {2'b00, 1'b1, g[0], 4'h0});
          wr(OFF_CMP_UP, $random(seed) & 3);
          wr(OFF_CMP_LO, $random(seed));
          wr(OFF_CTRL_ONE, 8'h02);
          r = (k == 0) ? mcv() : (k == 1) ? mcv() - 1 : $random(seed);
          conv(r);
          for (int a = 0; a < 4; a++) rd(a);
        end
      end
    end
    $display("compare test done");
    // Read interlock in 10-bit, none in 8-bit or reserved modes
    wr(OFF_CTRL_TWO, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_CONFIG, modes[i]);
      wr(OFF_CTRL_ONE, 8'h01);
      conv($random(seed));
      rd(OFF_RES_UP);
      wr(OFF_CTRL_ONE, 8'h01);
      conv($random(seed));
      rd(OFF_CTRL_ONE);
      rd(OFF_RES_LO);
      rd(OFF_RES_UP);
    end
    $display("interlock test done");
    // Hardware trigger: one start per rising edge
    wr(OFF_CONFIG, 8'h08);
    wr(OFF_CTRL_TWO, 8'hc0);
    repeat (4) @(posedge ref_clk_i);
    wr(OFF_CTRL_ONE, 8'h04);
    for (int i = 0; i < 3; i++) begin
      hardware_trigger_in_i <= 1'b1;
      n = 0;
      while (core_start_o !== 1'b1 && n < 8) begin
        @(posedge ref_clk_i);
        #1;
        n++;
      end
      chk(core_start_o, 1'b1);
      m_act = 1;
      conv($random(seed));
      repeat (6) @(posedge ref_clk_i);
      #1 chk(conversion_active_o, 1'b0);
      rd(OFF_RES_LO);
      hardware_trigger_in_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
    end
    $display("hardware trigger test done");
    results();
  end
endmodule
